/* pkg/sltc_consts.svh */
// Offsets, field positions, reset values and character codes of the link control register bank.
// Assumes it is included by bare name from design files that also import sltc_pkg.
//
// Overview of operation
// (R1) Sync select 0 takes the single-ended pin.
// (R2) Select 1 takes timestamp input when enabled.
// (R3) Select 2 uses only the software request.
// (R4) Format bit: 0 offset binary, 1 two's.
// (R5) Bit 0 enables scrambling; off after reset.
// (R6) Software writes settings only while link disabled.
// (R7) Pattern 0 normal; 1-3 pick PRBS7/15/23.
// (R8) Patterns 4-7: ramp, transport, D21.5, K28.5.
// (R9) 8 ILA, 9 RPAT, 10 low, 11 high.
// (R10) Device ID travels in alignment multiframe two.
// (R11) Link A sends ID, link B ID+1.
// (R12) Device ID bit 0 ignored, reads zero.
// (R13) Frame char: 0 K28.7, 1 K28.1, 2 K28.5.
// (R14) Frame char inserted opportunistically, not every frame.
// (R15) Compliant receivers: keep frame char at 0.
// (R16) Generic 8b/10b receivers: choose 1 or 2.
// (R17) Status bits 6,5,2 read-only; 4,3 writable.
// (R18) Status bit 6 high while link runs.
// (R19) Status bit 5 shows live sync level.
// (R20) Status bit 4 sticky realign; write 1 clears.
// (R21) Status bit 2 high while serializer PLL locked.
// (R22) Nonzero pattern other than 8 (ILA) replaces sample data on lanes.
`ifndef SLTC_CONSTS_SVH
`define SLTC_CONSTS_SVH

`define SLTC_ADDR_W           12
`define SLTC_IDX_LINK_CONTROL 10'h204
`define SLTC_IDX_TEST_PATTERN 10'h205
`define SLTC_IDX_DEVICE_ID    10'h206
`define SLTC_IDX_FRAME_CHAR   10'h207
`define SLTC_IDX_STATUS       10'h208
`define SLTC_IDX_AUX_CONTROL  10'h210

`define SLTC_RST_LINK_CONTROL 8'h02
`define SLTC_RST_TEST_PATTERN 8'h00
`define SLTC_RST_DEVICE_ID    8'h00
`define SLTC_RST_FRAME_CHAR   8'h00
`define SLTC_RST_AUX_CONTROL  8'h03

`define SLTC_CTL_SCR_BIT      0
`define SLTC_CTL_FMT_BIT      1
`define SLTC_CTL_SYNC_MSB     3
`define SLTC_CTL_SYNC_LSB     2
`define SLTC_TP_MSB           3
`define SLTC_FRAME_END_CHARACTER_MSB        1
`define SLTC_STS_REALIGN_BIT  4
`define SLTC_STS_ALIGN_BIT    3
`define SLTC_AUX_LINK_EN_BIT  0
`define SLTC_AUX_SW_SYNC_BIT  1
`define SLTC_AUX_TIMESTAMP_DIFF_INPUT_EN_BIT 2

`define SLTC_PIN_SE           0
`define SLTC_PIN_TIMESTAMP_DIFF_INPUT        1
`define SLTC_PIN_PLL          2
`define SLTC_PIN_RST          3'b011

`define SLTC_K28_7            8'hfc
`define SLTC_K28_1            8'h3c
`define SLTC_K28_5            8'hbc
`define SLTC_D21_5            8'hb5
`define SLTC_PRBS_SEED        23'h7fffff
`define SLTC_SCR_SEED         15'h7fff
`define SLTC_RPAT_LAST        4'hb

`endif

/* pkg/sltc_pkg.sv */
// Types shared by the link control register bank and its lane multiplexer.
// Assumes nothing of its surroundings.
package sltc_pkg;

  typedef enum logic [1:0] {
    SLTC_SYNC_PIN   = 2'h0,
    SLTC_SYNC_TIMESTAMP_DIFF_INPUT = 2'h1,
    SLTC_SYNC_SOFT  = 2'h2,
    SLTC_SYNC_RSVD  = 2'h3
  } sltc_sync_sel_t;

  typedef enum logic [3:0] {
    SLTC_TP_NORMAL    = 4'h0,
    SLTC_TP_PRBS7     = 4'h1,
    SLTC_TP_PRBS15    = 4'h2,
    SLTC_TP_PRBS23    = 4'h3,
    SLTC_TP_RAMP      = 4'h4,
    SLTC_TP_TRANSPORT = 4'h5,
    SLTC_TP_D21_5     = 4'h6,
    SLTC_TP_K28_5     = 4'h7,
    SLTC_TP_ILA       = 4'h8,
    SLTC_TP_RPAT      = 4'h9,
    SLTC_TP_LOW       = 4'ha,
    SLTC_TP_HIGH      = 4'hb
  } sltc_test_pattern_t;

  typedef enum logic [1:0] {
    SLTC_FC_K28_7 = 2'h0,
    SLTC_FC_K28_1 = 2'h1,
    SLTC_FC_K28_5 = 2'h2,
    SLTC_FC_RSVD  = 2'h3
  } sltc_frame_end_character_t;

endpackage : sltc_pkg

/* pkg/sltc_cfg_if.sv */
// Settings carried from the register bank to each lane multiplexer.
// Assumes sltc_pkg is compiled first.
`timescale 1ns/1ps
`default_nettype none

interface sltc_cfg_if;
  import sltc_pkg::*;

  logic               scrambler_enable;
  logic               sample_format_select;
  sltc_test_pattern_t test_pattern_select;
  sltc_frame_end_character_t        frame_end_character_select;

  modport regs (output scrambler_enable, sample_format_select, test_pattern_select, frame_end_character_select);
  modport lane (input scrambler_enable, sample_format_select, test_pattern_select, frame_end_character_select);
endinterface : sltc_cfg_if

`default_nettype wire

/* verilog/sltc_lane_mux.sv */
// Lane octet source: sample formatting, scrambling, frame character insertion and test patterns.
// Assumes one sample octet per clock and settings that only change while the link is disabled.
`timescale 1ns/1ps
`default_nettype none
`include "sltc_consts.svh"

module sltc_lane_mux
  import sltc_pkg::*;
#(
  parameter logic [95:0] RPAT_TABLE = 96'h0123456789abcdeffedcba98
)
(
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       nrst,
  // Settings.
  sltc_cfg_if.lane        cfg,
  // Sample octets.
  input  wire logic [7:0] sample_byte,
  input  wire logic       sample_msb,
  input  wire logic       frame_end,
  // Lane octet towards the encoder.
  output logic      [7:0] lane_data,
  output logic            lane_ctrl,
  output logic            ila_repeat
);

  function automatic logic [22:0] prbs_next(input logic [22:0] s, input sltc_test_pattern_t tp);
    logic [22:0] v;
    logic        fb;
    v = s;
    for (int i = 0; i < 8; i++)
    begin
      if (tp == SLTC_TP_PRBS7)
        fb = v[6] ^ v[5];
      else if (tp == SLTC_TP_PRBS15)
        fb = v[14] ^ v[13];
      else
        fb = v[22] ^ v[17];
      v = {v[21:0], fb};
    end
    return v;
  endfunction : prbs_next

  // Self-synchronous 1 + x^14 + x^15, most significant bit first; returns {octet, state}.
  function automatic logic [22:0] scramble(input logic [14:0] s, input logic [7:0] d);
    logic [14:0] v;
    logic        b;
    v = s;
    for (int i = 7; i >= 0; i--)
    begin
      b = d[i] ^ v[14] ^ v[13];
      v = {v[13:0], b};
    end
    return {v[7:0], v};
  endfunction : scramble

  logic [22:0] prbs_reg;
  logic [22:0] prbs_next_val;
  logic [14:0] scr_reg;
  logic [22:0] scr_out;
  logic [7:0]  ramp_reg;
  logic [3:0]  rpat_idx_reg;
  logic [7:0]  last_reg;
  logic [7:0]  formatted;
  logic [7:0]  payload;
  logic [7:0]  eof_char;
  logic        eof_hit;

  assign formatted     = sample_byte ^ {sample_msb & ~cfg.sample_format_select, 7'h00}; // R4
  assign scr_out       = scramble(scr_reg, formatted);
  assign payload       = cfg.scrambler_enable ? scr_out[22:15] : formatted; // R5
  assign prbs_next_val = prbs_next(prbs_reg, cfg.test_pattern_select);
  // Replace only when the frame's last octet repeats; scrambled lanes watch for the comma value itself.
  assign eof_hit = frame_end & (cfg.scrambler_enable ? (payload == `SLTC_K28_7) : (payload == last_reg)); // R14

  always_comb
  begin
    unique case (cfg.frame_end_character_select) // R13
      SLTC_FC_K28_1: eof_char = `SLTC_K28_1;
      SLTC_FC_K28_5: eof_char = `SLTC_K28_5;
      SLTC_FC_K28_7,
      SLTC_FC_RSVD:  eof_char = `SLTC_K28_7;
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      prbs_reg     <= `SLTC_PRBS_SEED;
      ramp_reg     <= 8'h00;
      rpat_idx_reg <= 4'h0;
    end
    else
    begin
      prbs_reg     <= prbs_next_val;
      ramp_reg     <= ramp_reg + 8'h01;
      rpat_idx_reg <= (rpat_idx_reg == `SLTC_RPAT_LAST) ? 4'h0 : rpat_idx_reg + 4'h1;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      scr_reg  <= `SLTC_SCR_SEED;
      last_reg <= 8'h00;
    end
    else
    begin
      scr_reg  <= cfg.scrambler_enable ? scr_out[14:0] : `SLTC_SCR_SEED; // R5
      last_reg <= frame_end ? payload : last_reg;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      lane_data  <= 8'h00;
      lane_ctrl  <= 1'b0;
      ila_repeat <= 1'b0;
    end
    else
    begin
      lane_ctrl  <= 1'b0;
      ila_repeat <= cfg.test_pattern_select == SLTC_TP_ILA; // R9
      unique case (cfg.test_pattern_select) // R22
        SLTC_TP_NORMAL,
        SLTC_TP_ILA:
        begin
          lane_data <= eof_hit ? eof_char : payload; // R7
          lane_ctrl <= eof_hit;
        end
        SLTC_TP_PRBS7,
        SLTC_TP_PRBS15,
        SLTC_TP_PRBS23:    lane_data <= prbs_next_val[7:0]; // R7
        SLTC_TP_RAMP:      lane_data <= ramp_reg; // R8
        SLTC_TP_TRANSPORT: lane_data <= {ramp_reg[3:0], ~ramp_reg[3:0]}; // R8
        SLTC_TP_D21_5:     lane_data <= `SLTC_D21_5; // R8
        SLTC_TP_K28_5:
        begin
          lane_data <= `SLTC_K28_5; // R8
          lane_ctrl <= 1'b1;
        end
        SLTC_TP_RPAT:      lane_data <= RPAT_TABLE[95 - 8 * rpat_idx_reg -: 8]; // R9
        SLTC_TP_LOW:       lane_data <= 8'h00; // R9
        SLTC_TP_HIGH:      lane_data <= 8'hff; // R9
        default:           lane_data <= 8'h00;
      endcase
    end
  end

  default clocking lane_cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence hold_low_s;
    cfg.test_pattern_select == SLTC_TP_LOW [*2];
  endsequence

  AST_FORMAT_MSB: assert property ( // R4
    (cfg.test_pattern_select == SLTC_TP_NORMAL && !cfg.scrambler_enable && !frame_end && sample_msb)
    |=> lane_data[7] == ($past(sample_byte[7]) ^ !$past(cfg.sample_format_select)))
    else $error("Sample format not applied to the sign octet.");

  AST_SCR_OFF: assert property ( // R5
    (cfg.test_pattern_select == SLTC_TP_NORMAL && !cfg.scrambler_enable && !frame_end && !sample_msb)
    |=> lane_data == $past(sample_byte) && !lane_ctrl)
    else $error("Unscrambled octet altered on the lane.");

  AST_K28_5: assert property ( // R8
    cfg.test_pattern_select == SLTC_TP_K28_5 |=> lane_data == `SLTC_K28_5 && lane_ctrl)
    else $error("K28.5 pattern not sent.");

  AST_HOLD_LOW: assert property ( // R9
    hold_low_s |-> ##1 lane_data == 8'h00 && !lane_ctrl)
    else $error("Lane not held low.");

endmodule : sltc_lane_mux

`default_nettype wire

/* verilog/sltc_top.sv */
// Register bank of the serial link transmit path with its sync selection and two lane multiplexers.
// Assumes an Avalon-MM master on CLK, asynchronous sync and lock pins, and a same-clock realign pulse.
`timescale 1ns/1ps
`default_nettype none
`include "sltc_consts.svh"

module sltc_top
  import sltc_pkg::*;
(
  // Clock and reset.
  input  wire logic                    CLK,
  input  wire logic                    NRST,
  // Avalon-MM slave, byte addressed, one register per aligned 32-bit word.
  input  wire logic [`SLTC_ADDR_W-1:0] AVS_ADDRESS,
  input  wire logic                    AVS_READ,
  input  wire logic                    AVS_WRITE,
  input  wire logic [31:0]             AVS_WRITEDATA,
  input  wire logic [3:0]              AVS_BYTEENABLE,
  output logic      [31:0]             AVS_READDATA,
  output logic                         AVS_WAITREQUEST,
  // Pins from outside the clock domain.
  input  wire logic                    SYNC_SE_N,
  input  wire logic                    TIMESTAMP_DIFF_INPUT_SYNC_N,
  input  wire logic                    SER_PLL_LOCKED,
  // Same-clock event from the reference alignment logic.
  input  wire logic                    SYSREF_REALIGN,
  // Sample octets for link A and link B.
  input  wire logic [7:0]              SAMPLE_A_BYTE,
  input  wire logic                    SAMPLE_A_MSB,
  input  wire logic                    SAMPLE_A_FRAME_END,
  input  wire logic [7:0]              SAMPLE_B_BYTE,
  input  wire logic                    SAMPLE_B_MSB,
  input  wire logic                    SAMPLE_B_FRAME_END,
  // Lane octets.
  output logic      [7:0]              LANE_A_DATA,
  output logic                         LANE_A_CTRL,
  output logic      [7:0]              LANE_B_DATA,
  output logic                         LANE_B_CTRL,
  // Link layer controls.
  output logic                         ILA_REPEAT,
  output logic                         LINK_SYNC_N,
  output logic                         LINK_ENABLE,
  output logic                         TIMESTAMP_RECEIVER_ENABLE,
  output logic      [7:0]              ILA_DEVICE_ID_A,
  output logic      [7:0]              ILA_DEVICE_ID_B
);

  function automatic logic addr_is(input logic [`SLTC_ADDR_W-1:0] addr, input logic [9:0] idx);
    return addr == {idx, 2'b00};
  endfunction : addr_is

  logic [7:0]     link_control_reg;
  logic [7:0]     test_pattern_reg;
  logic [7:0]     device_id_reg;
  logic [7:0]     frame_char_reg;
  logic [7:0]     aux_reg;
  logic           realigned_reg;
  logic           phase_alignment_flag_reg;
  logic [2:0]     pin_s1_reg;
  logic [2:0]     pin_s2_reg;
  logic [2:0]     pin_s3_reg;
  logic [2:0]     pin_lvl_reg;
  logic           sync_n_reg;
  logic           sync_next;
  logic           link_up_reg;
  logic           wait_reg;
  logic [31:0]    readdata_reg;
  logic [7:0]     did_a_reg;
  logic [7:0]     did_b_reg;
  logic [7:0]     read_byte;
  logic [7:0]     status_byte;
  logic           req;
  logic           ack;
  logic           wr;
  logic           wd_link_ctrl;
  logic           wd_test;
  logic           wd_did;
  logic           wd_frame_end_character;
  logic           wd_status;
  logic           wd_aux;
  sltc_sync_sel_t sync_sel;
  logic           sw_sync_n;
  logic           timestamp_diff_input_en;

  sltc_cfg_if cfg ();

  // Bus handshake: one wait cycle, then the access completes on the edge that sees waitrequest low.
  assign req  = AVS_READ | AVS_WRITE;
  assign ack  = req & ~wait_reg;
  assign wr   = AVS_WRITE & ~wait_reg & AVS_BYTEENABLE[0];

  assign wd_link_ctrl = wr & addr_is(AVS_ADDRESS, `SLTC_IDX_LINK_CONTROL);
  assign wd_test      = wr & addr_is(AVS_ADDRESS, `SLTC_IDX_TEST_PATTERN);
  assign wd_did       = wr & addr_is(AVS_ADDRESS, `SLTC_IDX_DEVICE_ID);
  assign wd_frame_end_character     = wr & addr_is(AVS_ADDRESS, `SLTC_IDX_FRAME_CHAR);
  assign wd_status    = wr & addr_is(AVS_ADDRESS, `SLTC_IDX_STATUS);
  assign wd_aux       = wr & addr_is(AVS_ADDRESS, `SLTC_IDX_AUX_CONTROL);

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      wait_reg     <= 1'b1;
      readdata_reg <= 32'h0000_0000;
    end
    else
    begin
      wait_reg <= ack | ~req;
      if (req & wait_reg)
        readdata_reg <= {24'h00_0000, read_byte};
    end
  end

  // Settings registers; all but aux_reg, which holds the link enable, are expected to change only while the link is disabled.
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      link_control_reg <= `SLTC_RST_LINK_CONTROL; // R5
      test_pattern_reg <= `SLTC_RST_TEST_PATTERN;
      device_id_reg    <= `SLTC_RST_DEVICE_ID;
      frame_char_reg   <= `SLTC_RST_FRAME_CHAR;
      aux_reg          <= `SLTC_RST_AUX_CONTROL;
    end
    else
    begin
      if (wd_link_ctrl)
        link_control_reg <= AVS_WRITEDATA[7:0];
      if (wd_test)
        test_pattern_reg <= AVS_WRITEDATA[7:0];
      if (wd_did)
        device_id_reg <= {AVS_WRITEDATA[7:1], 1'b0}; // R12
      if (wd_frame_end_character)
        frame_char_reg <= AVS_WRITEDATA[7:0];
      if (wd_aux)
        aux_reg <= AVS_WRITEDATA[7:0];
    end
  end

  // Realign is sticky and write-one-to-clear; a new event in the clearing cycle wins.
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      realigned_reg <= 1'b0;
      phase_alignment_flag_reg   <= 1'b0;
    end
    else
    begin
      realigned_reg <= SYSREF_REALIGN | (realigned_reg & ~(wd_status & AVS_WRITEDATA[`SLTC_STS_REALIGN_BIT])); // R20
      if (wd_status)
        phase_alignment_flag_reg <= AVS_WRITEDATA[`SLTC_STS_ALIGN_BIT]; // R17
    end
  end

  // Pins pass three flops; a new level counts once the second and third agree.
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      pin_s1_reg  <= `SLTC_PIN_RST;
      pin_s2_reg  <= `SLTC_PIN_RST;
      pin_s3_reg  <= `SLTC_PIN_RST;
      pin_lvl_reg <= `SLTC_PIN_RST;
    end
    else
    begin
      pin_s1_reg  <= {SER_PLL_LOCKED, TIMESTAMP_DIFF_INPUT_SYNC_N, SYNC_SE_N};
      pin_s2_reg  <= pin_s1_reg;
      pin_s3_reg  <= pin_s2_reg;
      pin_lvl_reg <= (pin_s2_reg & ~(pin_s2_reg ^ pin_s3_reg)) | (pin_lvl_reg & (pin_s2_reg ^ pin_s3_reg));
    end
  end

  assign sync_sel  = sltc_sync_sel_t'(link_control_reg[`SLTC_CTL_SYNC_MSB:`SLTC_CTL_SYNC_LSB]);
  assign sw_sync_n = aux_reg[`SLTC_AUX_SW_SYNC_BIT];
  assign timestamp_diff_input_en  = aux_reg[`SLTC_AUX_TIMESTAMP_DIFF_INPUT_EN_BIT];

  // The software request always acts; a stuck pin can be bypassed with select 2 or 3, or with select 1 while the timestamp input is disabled.
  always_comb
  begin
    unique case (sync_sel)
      SLTC_SYNC_PIN:   sync_next = pin_lvl_reg[`SLTC_PIN_SE] & sw_sync_n; // R1
      SLTC_SYNC_TIMESTAMP_DIFF_INPUT: sync_next = (pin_lvl_reg[`SLTC_PIN_TIMESTAMP_DIFF_INPUT] | ~timestamp_diff_input_en) & sw_sync_n; // R2
      SLTC_SYNC_SOFT,
      SLTC_SYNC_RSVD:  sync_next = sw_sync_n; // R3
    endcase
  end

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      sync_n_reg  <= 1'b1;
      link_up_reg <= 1'b0;
      did_a_reg   <= 8'h00;
      did_b_reg   <= 8'h00;
    end
    else
    begin
      sync_n_reg  <= sync_next;
      link_up_reg <= aux_reg[`SLTC_AUX_LINK_EN_BIT] & pin_lvl_reg[`SLTC_PIN_PLL] & sync_n_reg; // R18
      did_a_reg   <= device_id_reg; // R10
      did_b_reg   <= device_id_reg + 8'h01; // R11
    end
  end

  assign status_byte = {1'b0, link_up_reg, sync_n_reg, realigned_reg, phase_alignment_flag_reg, // R17
                        pin_lvl_reg[`SLTC_PIN_PLL], 2'b00}; // R21

  always_comb
  begin
    read_byte = 8'h00;
    if (addr_is(AVS_ADDRESS, `SLTC_IDX_LINK_CONTROL))
      read_byte = link_control_reg;
    else if (addr_is(AVS_ADDRESS, `SLTC_IDX_TEST_PATTERN))
      read_byte = test_pattern_reg;
    else if (addr_is(AVS_ADDRESS, `SLTC_IDX_DEVICE_ID))
      read_byte = device_id_reg;
    else if (addr_is(AVS_ADDRESS, `SLTC_IDX_FRAME_CHAR))
      read_byte = frame_char_reg;
    else if (addr_is(AVS_ADDRESS, `SLTC_IDX_STATUS))
      read_byte = status_byte; // R19
    else if (addr_is(AVS_ADDRESS, `SLTC_IDX_AUX_CONTROL))
      read_byte = aux_reg;
  end

  assign cfg.scrambler_enable           = link_control_reg[`SLTC_CTL_SCR_BIT];
  assign cfg.sample_format_select       = link_control_reg[`SLTC_CTL_FMT_BIT];
  assign cfg.test_pattern_select        = sltc_test_pattern_t'(test_pattern_reg[`SLTC_TP_MSB:0]);
  assign cfg.frame_end_character_select = sltc_frame_end_character_t'(frame_char_reg[`SLTC_FRAME_END_CHARACTER_MSB:0]);

  sltc_lane_mux u_lane_a (
    .clk         (CLK),
    .nrst        (NRST),
    .cfg         (cfg.lane),
    .sample_byte (SAMPLE_A_BYTE),
    .sample_msb  (SAMPLE_A_MSB),
    .frame_end   (SAMPLE_A_FRAME_END),
    .lane_data   (LANE_A_DATA),
    .lane_ctrl   (LANE_A_CTRL),
    .ila_repeat  (ILA_REPEAT)
  );

  sltc_lane_mux u_lane_b (
    .clk         (CLK),
    .nrst        (NRST),
    .cfg         (cfg.lane),
    .sample_byte (SAMPLE_B_BYTE),
    .sample_msb  (SAMPLE_B_MSB),
    .frame_end   (SAMPLE_B_FRAME_END),
    .lane_data   (LANE_B_DATA),
    .lane_ctrl   (LANE_B_CTRL),
    .ila_repeat  ()
  );

  assign AVS_READDATA              = readdata_reg;
  assign AVS_WAITREQUEST           = wait_reg;
  assign LINK_SYNC_N               = sync_n_reg;
  assign LINK_ENABLE               = aux_reg[`SLTC_AUX_LINK_EN_BIT];
  assign TIMESTAMP_RECEIVER_ENABLE = aux_reg[`SLTC_AUX_TIMESTAMP_DIFF_INPUT_EN_BIT];
  assign ILA_DEVICE_ID_A           = did_a_reg;
  assign ILA_DEVICE_ID_B           = did_b_reg;

  default clocking top_cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  sequence did_write_s;
    wd_did ##1 !wd_did [*2];
  endsequence

  sequence realign_clear_s;
    wd_status && AVS_WRITEDATA[`SLTC_STS_REALIGN_BIT] && !SYSREF_REALIGN;
  endsequence

  AST_SYNC_PIN: assert property ( // R1
    (sync_sel == SLTC_SYNC_PIN && sw_sync_n) |=> sync_n_reg == $past(pin_lvl_reg[`SLTC_PIN_SE]))
    else $error("Sync does not follow the single-ended pin.");

  AST_SYNC_TIMESTAMP_DIFF_INPUT: assert property ( // R2
    (sync_sel == SLTC_SYNC_TIMESTAMP_DIFF_INPUT && sw_sync_n) |=> sync_n_reg == ($past(pin_lvl_reg[`SLTC_PIN_TIMESTAMP_DIFF_INPUT]) | !$past(timestamp_diff_input_en)))
    else $error("Sync does not follow the timestamp input.");

  AST_SYNC_SOFT: assert property ( // R3
    sync_sel == SLTC_SYNC_SOFT |=> sync_n_reg == $past(sw_sync_n))
    else $error("Sync pins not ignored in software mode.");

  AST_DID_EVEN: assert property ( // R12
    did_write_s |-> ILA_DEVICE_ID_A[0] == 1'b0 && ILA_DEVICE_ID_A[7:1] == $past(AVS_WRITEDATA[7:1], 3))
    else $error("Device ID low bit not dropped.");

  AST_DID_LINK_B: assert property ( // R11
    did_write_s |-> ILA_DEVICE_ID_B == ILA_DEVICE_ID_A + 8'h01)
    else $error("Link B device ID is not link A plus one.");

  AST_REALIGN_SET: assert property ( // R20
    SYSREF_REALIGN |=> realigned_reg [*1] ##0 status_byte[`SLTC_STS_REALIGN_BIT])
    else $error("Realign event lost.");

  AST_REALIGN_CLEAR: assert property ( // R20
    realign_clear_s |=> !realigned_reg)
    else $error("Realign flag not cleared by writing one.");

  AST_LINK_UP: assert property ( // R18
    (!aux_reg[`SLTC_AUX_LINK_EN_BIT] || !pin_lvl_reg[`SLTC_PIN_PLL]) |=> !status_byte[6])
    else $error("Link reported up while disabled or unlocked.");

  AST_PLL: assert property ( // R21
    $rose(pin_s3_reg[`SLTC_PIN_PLL]) && pin_s2_reg[`SLTC_PIN_PLL] |=> status_byte[2])
    else $error("Lock status not reported.");

  AST_BUS_WAIT: assert property (
    (req && wait_reg) |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST || !req)
    else $error("Bus access not answered after one wait cycle.");

endmodule : sltc_top

`default_nettype wire

/* bench/sltc_rx_model.sv */
// Receiver-side model: drives the single-ended sync pin on request.
// Assumes the bench sets req; the flop drives the pin high from reset and while req is low.
`timescale 1ns/1ps
`default_nettype none

module sltc_rx_model (
  // Clock, reset and request from the bench.
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic req,
  // Active-low sync request pin.
  output logic      sync_n
);
  // The request leaves a flop, as a real receiver's would, so it never glitches.
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      sync_n <= 1'b1;
    else
      sync_n <= ~req;
endmodule : sltc_rx_model

`default_nettype wire

/* bench/tb_top.sv */
// Self-checking bench for the link control register bank, its sync selection and lane patterns.
// Assumes sltc_top with its package and interface compiled first, and the receiver model.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import sltc_pkg::*;
  logic        CLK = 0, NRST = 0, AVS_READ = 0, AVS_WRITE = 0, TIMESTAMP_DIFF_INPUT_SYNC_N = 1, SER_PLL_LOCKED = 0;
  logic        SYSREF_REALIGN = 0, msb = 0, rx_req = 0, AVS_WAITREQUEST, SYNC_SE_N, LANE_A_CTRL;
  logic        LANE_B_CTRL, ILA_REPEAT, LINK_SYNC_N, LINK_ENABLE, ts_en, fe = 0;
  logic [11:0] AVS_ADDRESS = 0;
  logic [31:0] AVS_WRITEDATA = 0, AVS_READDATA;
  logic [7:0]  smp = 0, q, LANE_A_DATA, LANE_B_DATA, ILA_DEVICE_ID_A, ILA_DEVICE_ID_B;
  int          n_errors = 0, checks = 0, cyc = 0;

  always #10 CLK = ~CLK;

  sltc_top dut (.CLK, .NRST, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA, .AVS_BYTEENABLE(4'h1),
    .AVS_READDATA, .AVS_WAITREQUEST, .SYNC_SE_N, .TIMESTAMP_DIFF_INPUT_SYNC_N, .SER_PLL_LOCKED, .SYSREF_REALIGN,
    .SAMPLE_A_BYTE(smp), .SAMPLE_A_MSB(msb), .SAMPLE_A_FRAME_END(fe), .SAMPLE_B_BYTE(smp),
    .SAMPLE_B_MSB(msb), .SAMPLE_B_FRAME_END(1'b0), .LANE_A_DATA, .LANE_A_CTRL, .LANE_B_DATA,
    .LANE_B_CTRL, .ILA_REPEAT, .LINK_SYNC_N, .LINK_ENABLE, .TIMESTAMP_RECEIVER_ENABLE(ts_en),
    .ILA_DEVICE_ID_A, .ILA_DEVICE_ID_B);
  sltc_rx_model rx (.clk(CLK), .nrst(NRST), .req(rx_req), .sync_n(SYNC_SE_N));

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop

  // Stop a hung run well beyond the few hundred cycles the tests need.
  always @(posedge CLK)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_errors++;
      report_and_stop();
    end
  end

  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // One Avalon access; the request holds until the edge that sees waitrequest low.
  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge CLK);
    AVS_ADDRESS   <= a;
    AVS_WRITE     <= w;
    AVS_READ      <= !w;
    AVS_WRITEDATA <= {24'h0, d};
    do @(posedge CLK); while (AVS_WAITREQUEST !== 1'b0 && ++n < 50);
    if (n >= 50)
      n_errors++;
    q = AVS_READDATA[7:0];
    AVS_WRITE <= 1'b0;
    AVS_READ  <= 1'b0;
  endtask : bus

  task automatic rdc(input logic [11:0] a, input logic [7:0] e, input string nm);
    bus(1'b0, a, 8'h00);
    chk(nm, q, e);
  endtask : rdc

  task automatic wt(input int n);
    repeat (n) @(negedge CLK);
  endtask : wt

  task automatic t_reset();
    rdc(12'h810, 8'h02, "ctrl");
    rdc(12'h814, 8'h00, "test");
    rdc(12'h81c, 8'h00, "frame_end_character");
    rdc(12'h820, 8'h20, "status");
    rdc(12'h824, 8'h00, "unmapped");
    bus(1'b1, 12'h840, 8'h02);
    $display("reset test done");
  endtask : t_reset

  task automatic t_did_status();
    bus(1'b1, 12'h818, 8'h07);
    rdc(12'h818, 8'h06, "did");
    wt(2);
    chk("id_a", ILA_DEVICE_ID_A, 8'h06);
    chk("id_b", ILA_DEVICE_ID_B, 8'h07);
    bus(1'b1, 12'h820, 8'hff);
    rdc(12'h820, 8'h28, "sts_wr");
    @(posedge CLK) SYSREF_REALIGN <= 1'b1;
    @(posedge CLK) SYSREF_REALIGN <= 1'b0;
    rdc(12'h820, 8'h38, "sts_set");
    bus(1'b1, 12'h820, 8'h10);
    rdc(12'h820, 8'h20, "sts_clr");
    $display("id and status test done");
  endtask : t_did_status

  task automatic t_sync();
    @(posedge CLK) rx_req <= 1'b1;
    wt(8);
    chk("sync_pin", {7'h00, LINK_SYNC_N}, 8'h00);
    rdc(12'h820, 8'h00, "sts_sync");
    bus(1'b1, 12'h810, 8'h0a);
    wt(8);
    chk("sync_soft", {7'h00, LINK_SYNC_N}, 8'h01);
    bus(1'b1, 12'h840, 8'h00);
    wt(4);
    chk("sync_req", {7'h00, LINK_SYNC_N}, 8'h00);
    bus(1'b1, 12'h840, 8'h06);
    bus(1'b1, 12'h810, 8'h06);
    TIMESTAMP_DIFF_INPUT_SYNC_N <= 1'b0;
    chk("ts_en", {7'h00, ts_en}, 8'h01);
    chk("link_off", {7'h00, LINK_ENABLE}, 8'h00);
    wt(8);
    chk("sync_ts", {7'h00, LINK_SYNC_N}, 8'h00);
    bus(1'b1, 12'h810, 8'h02);
    rx_req <= 1'b0;
    bus(1'b1, 12'h840, 8'h03);
    SER_PLL_LOCKED <= 1'b1;
    wt(8);
    chk("link_en", {7'h00, LINK_ENABLE}, 8'h01);
    rdc(12'h820, 8'h64, "sts_up");
    bus(1'b1, 12'h840, 8'h02);
    $display("sync test done");
  endtask : t_sync

  task automatic t_pattern();
    logic [3:0] p [4] = '{4'h6, 4'h7, 4'ha, 4'hb};
    logic [7:0] e [4] = '{8'hb5, 8'hbc, 8'h00, 8'hff};
    smp <= 8'h12;
    msb <= 1'b1;
    bus(1'b1, 12'h810, 8'h00);
    wt(3);
    chk("offset", LANE_A_DATA, 8'h92);
    bus(1'b1, 12'h810, 8'h02);
    wt(3);
    chk("twos", LANE_A_DATA, 8'h12);
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b1, 12'h814, {4'h0, p[i]});
      wt(3);
      chk("lane_a", LANE_A_DATA, e[i]);
      chk("lane_b", LANE_B_DATA, e[i]);
      chk("k_ctrl", {7'h00, LANE_A_CTRL}, {7'h00, i == 1});
      chk("kb_ctrl", {7'h00, LANE_B_CTRL}, {7'h00, i == 1});
    end
    bus(1'b1, 12'h814, 8'h08);
    wt(3);
    chk("ila", {7'h00, ILA_REPEAT}, 8'h01);
    bus(1'b1, 12'h814, 8'h00);
    wt(3);
    chk("normal", LANE_B_DATA, 8'h12);
    // The scrambler restarts from its seed, so the second scrambled octet is known.
    bus(1'b1, 12'h810, 8'h03);
    wt(3);
    chk("scr", LANE_A_DATA, 8'h10);
    bus(1'b1, 12'h810, 8'h02);
    bus(1'b1, 12'h81c, 8'h01);
    fe <= 1'b1;
    wt(3);
    chk("fchar1", LANE_A_DATA, 8'h3c);
    chk("eof_k", {7'h00, LANE_A_CTRL}, 8'h01);
    chk("eof_b", LANE_B_DATA, 8'h12);
    bus(1'b1, 12'h81c, 8'h02);
    wt(2);
    chk("fchar2", LANE_A_DATA, 8'hbc);
    bus(1'b1, 12'h81c, 8'h00);
    fe <= 1'b0;
    $display("pattern test done");
  endtask : t_pattern

  initial
  begin
    repeat (20) @(posedge CLK);
    NRST <= 1'b1;
    t_reset();
    t_did_status();
    t_sync();
    t_pattern();
    report_and_stop();
  end
endmodule : tb_top

`default_nettype wire
